// ---- logic/iwd_pkg.sv ----
package iwd_pkg;
    // register bus shape
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // register offsets (byte addresses)
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [3:0] OFS_REFRESH = 4'h8;
    localparam logic [3:0] OFS_MASK    = 4'hc;

    // control field positions
    localparam int unsigned TOPS_POS = 0;
    localparam int unsigned CKS_POS  = 4;
    localparam int unsigned RPES_POS = 8;
    localparam int unsigned RPSS_POS = 12;

    // status field positions
    localparam int unsigned CNT_W    = 14;
    localparam int unsigned UNDF_POS = 14;
    localparam int unsigned REFE_POS = 15;

    // reset values
    localparam logic [15:0] CONTROL_RST = 16'h3303;
    localparam logic [15:0] MASK_RST    = 16'h0000;
    localparam logic [13:0] CNT_RST     = 14'h3fff;

    // writable bits of the control register
    localparam logic [15:0] CONTROL_WMASK = 16'h33f3;

    // divider codes of the clock divider select field
    localparam logic [3:0] CKS_DIV1   = 4'h0;
    localparam logic [3:0] CKS_DIV16  = 4'h2;
    localparam logic [3:0] CKS_DIV32  = 4'h3;
    localparam logic [3:0] CKS_DIV64  = 4'h4;
    localparam logic [3:0] CKS_DIV128 = 4'hf;
    localparam logic [3:0] CKS_DIV256 = 4'h5;

    // count periods selected by the time-out field
    localparam logic [14:0] PERIOD_0 = 15'h0400;
    localparam logic [14:0] PERIOD_1 = 15'h1000;
    localparam logic [14:0] PERIOD_2 = 15'h2000;
    localparam logic [14:0] PERIOD_3 = 15'h4000;

    // counter state
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_COUNT = 2'b01,
        ST_UNDER = 2'b10
    } iwd_state_type;
endpackage

// ---- logic/iwd_div_if.sv ----
`timescale 1ns/100ps
// carries the synchronised source tick and divider choice to the prescaler
interface iwd_div_if;
    logic       tick;     // one pulse per source clock rising edge
    logic       run;      // prescaler counts only while high
    logic [3:0] div_sel;  // clock divider select code
    logic       cnt_en;   // one-cycle counter clock enable

    modport ctrl (output tick, output run, output div_sel, input cnt_en);
    modport presc (input tick, input run, input div_sel, output cnt_en);
endinterface

// ---- logic/iwd_prescaler.sv ----
`timescale 1ns/100ps
module iwd_prescaler
    import iwd_pkg::*;
(
    // clock and reset
    input  wire logic CLOCK_IN,
    input  wire logic RST_N_IN,
    // link to control logic
    iwd_div_if.presc  div
);
    logic [7:0] presc_q;  // free tick counter
    logic [7:0] presc_d;  // next count
    logic [7:0] ratio_m;  // ratio minus one, as a mask
    logic       legal;    // code is one of the six allowed
    logic       wrap;     // prescaler at last count of a period

    // decode ratio; prohibited codes stall the counter clock
    always_comb begin
        legal   = 1'b1;
        ratio_m = 8'h00;
        unique case (div.div_sel)
            CKS_DIV1:   ratio_m = 8'h00;
            CKS_DIV16:  ratio_m = 8'h0f;
            CKS_DIV32:  ratio_m = 8'h1f;
            CKS_DIV64:  ratio_m = 8'h3f;
            CKS_DIV128: ratio_m = 8'h7f;
            CKS_DIV256: ratio_m = 8'hff;
            default:    legal   = 1'b0;
        endcase
    end

    assign wrap       = ((presc_q & ratio_m) == ratio_m);
    assign div.cnt_en = div.tick & div.run & legal & wrap;
    assign presc_d    = div.run ? (presc_q + 8'h01) : 8'h00;

    // prescaler restarts whenever counting stops
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            presc_q <= 8'h00;
        end else if (div.tick || !div.run) begin
            presc_q <= presc_d;
        end
    end
endmodule // iwd_prescaler

// ---- logic/iwd_watchdog.sv ----
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
module iwd_watchdog
    import iwd_pkg::*;
(
    // clock and reset
    input  wire logic              CLOCK_IN,
    input  wire logic              RST_N_IN,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR_IN,
    input  wire logic [DATA_W-1:0] WDATA_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    output logic      [DATA_W-1:0] RDATA_OUT,
    // watchdog source clock pin
    input  wire logic              SRC_CLK_IN,
    // events
    output logic                   UNDERFLOW_OUT,
    output logic                   IRQ_OUT
);
    iwd_div_if div ();  // link to the prescaler

    // source clock synchroniser and edge detect
    logic src_meta_q;   // first stage, read only by second
    logic src_sync_q;   // second stage
    logic src_last_q;   // previous synchronised level
    logic src_rise;     // rising edge of source clock

    // registers
    logic [15:0]   ctrl_q;    // watchdog_control
    logic [15:0]   ctrl_d;
    logic [15:0]   mask_q;    // interrupt mask, status layout
    logic [15:0]   mask_d;
    logic [13:0]   cnt_q;     // counter_value
    logic [13:0]   cnt_d;
    logic          undf_q;    // underflow_flag
    logic          refe_q;    // refresh_error_flag
    logic [1:0]    flag_set;  // flag set events, refresh error on top
    logic [1:0]    flag_clr;  // one-to-clear strobes, same layout
    logic [1:0]    flag_q;    // sticky flags, status bits 15:14
    iwd_state_type state_q;   // counter state
    iwd_state_type state_d;
    logic [15:0]   rdata_q;   // read data register
    logic [15:0]   rdata_d;
    logic          undf_ev_q; // registered underflow pulse

    // address decode
    logic sel_ctrl;    // control selected
    logic sel_stat;    // status selected
    logic sel_ref;     // refresh selected
    logic sel_mask;    // mask selected
    logic wr_ctrl;     // control write
    logic wr_stat;     // status write, one-to-clear
    logic wr_ref;      // refresh request
    logic wr_mask;     // mask write

    // control fields
    logic [1:0] tops;  // timeout_period_select
    logic [3:0] cks;   // clock_divider_select
    logic [1:0] rpes;  // window_end_select
    logic [1:0] rpss;  // window_start_select

    // window and period arithmetic
    logic [14:0] period;     // count period in counter clocks
    logic [14:0] quarter;    // one quarter of the period
    logic [2:0]  start_q4;   // window opening, in quarters
    logic [2:0]  end_q4;     // window closing, in quarters
    logic [14:0] start_lim;  // count below which window is open
    logic [14:0] end_lim;    // count at or above which window is open
    logic [14:0] cnt_ext;    // counter widened for compare
    logic        in_window;  // refresh is permitted now
    logic        ref_ok;     // accepted refresh
    logic        ref_bad;    // refresh error event
    logic        undf_ev;    // counter steps below zero
    logic [13:0] reload;     // top count of the period
    logic [15:0] status;     // assembled status word
    logic        below_start; // count under the opening limit
    logic        above_end;   // count at or over the closing limit
    logic        counting;    // counter is running
    logic        cnt_zero;    // counter sits at zero
    logic [13:0] cnt_dec;     // counter one step down
    logic [1:0]  irq_flags;   // flags that pass the mask

    // two flops before any logic sees the pin
    // the pin must stay high and low two system clocks at least,
    // or a source edge can slip through unseen
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            src_meta_q <= 1'b0;
            src_sync_q <= 1'b0;
            src_last_q <= 1'b0;
        end else begin
            src_meta_q <= SRC_CLK_IN;
            src_sync_q <= src_meta_q;
            src_last_q <= src_sync_q;
        end
    end

    assign src_rise = src_sync_q & ~src_last_q;

    // bus decode, continuous and named
    // exact decode; aliases would let a stray write refresh the timer
    assign sel_ctrl = (ADDR_IN == OFS_CONTROL);
    assign sel_stat = (ADDR_IN == OFS_STATUS);
    assign sel_ref  = (ADDR_IN == OFS_REFRESH);
    assign sel_mask = (ADDR_IN == OFS_MASK);
    assign wr_ctrl  = WR_IN & sel_ctrl;
    assign wr_stat  = WR_IN & sel_stat;
    assign wr_ref   = WR_IN & sel_ref;
    assign wr_mask  = WR_IN & sel_mask;

    // field extraction from the control register
    // reserved bits never reach the fields, they read back zero
    assign tops = ctrl_q[TOPS_POS +: 2];
    assign cks  = ctrl_q[CKS_POS +: 4];
    assign rpes = ctrl_q[RPES_POS +: 2];
    assign rpss = ctrl_q[RPSS_POS +: 2];

    // counter helpers shared by the window and state logic
    assign counting = (state_q == ST_COUNT);
    assign cnt_zero = (cnt_q == 14'h0000);
    assign cnt_dec  = cnt_q - 14'h0001;

    // prescaler hookup; prohibited codes simply stop the count
    // a frozen count is safer than guessing a ratio for a bad code
    assign div.tick    = src_rise;
    assign div.run     = counting;
    assign div.div_sel = cks;

    iwd_prescaler u_presc (
        .CLOCK_IN (CLOCK_IN),
        .RST_N_IN (RST_N_IN),
        .div      (div)
    );

    // period chosen by the time-out field
    // longer periods trade reaction time for fewer refreshes
    always_comb begin
        period = PERIOD_0;
        unique case (tops)
            2'b00: period = PERIOD_0;
            2'b01: period = PERIOD_1;
            2'b10: period = PERIOD_2;
            2'b11: period = PERIOD_3;
        endcase
    end

    // window opening: 75, 50, 25 or 100 percent of the period left
    always_comb begin
        start_q4 = 3'd3;
        unique case (rpss)
            2'b00: start_q4 = 3'd3;
            2'b01: start_q4 = 3'd2;
            2'b10: start_q4 = 3'd1;
            2'b11: start_q4 = 3'd4;
        endcase
    end

    // window closing: 75, 50, 25 or 0 percent of the period left
    always_comb begin
        end_q4 = 3'd3;
        unique case (rpes)
            2'b00: end_q4 = 3'd3;
            2'b01: end_q4 = 3'd2;
            2'b10: end_q4 = 3'd1;
            2'b11: end_q4 = 3'd0;
        endcase
    end

    // limits in counter units; start 100 percent opens the whole period
    assign quarter   = period >> 2;
    assign start_lim = 15'(quarter * start_q4);
    assign end_lim   = 15'(quarter * end_q4);
    assign cnt_ext   = {1'b0, cnt_q};
    assign reload    = 14'(period - 15'h0001);

    // window bounds compared against the live count
    // the opening limit is exclusive, the closing limit inclusive
    assign below_start = (cnt_ext < start_lim);
    assign above_end   = (cnt_ext >= end_lim);

    // an end at or past the start leaves an empty window, all refreshes while counting fail
    assign in_window = below_start & above_end;

    // first refresh starts counting and always counts as good
    // a refresh while stopped never flags an error
    assign ref_ok  = wr_ref & (~counting | in_window);
    assign ref_bad = wr_ref & counting & ~in_window;

    // counter clock at zero means the count runs out
    // an accepted refresh on that same edge wins; a refused one does not
    assign undf_ev = div.cnt_en & cnt_zero & ~ref_ok;

    // counter state and value
    // the count holds while stopped, so status still shows it
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            ST_IDLE: begin
                // waits for the first refresh
                if (ref_ok) begin
                    state_d = ST_COUNT;
                    cnt_d   = reload;
                end
            end
            ST_COUNT: begin
                // refresh first, then underflow, then a plain step
                if (ref_ok) begin
                    cnt_d = reload;  // good refresh restarts the period
                end else if (undf_ev) begin
                    state_d = ST_UNDER;
                end else if (div.cnt_en) begin
                    cnt_d = cnt_dec;
                end
            end
            ST_UNDER: begin
                // stays at zero until software refreshes again
                if (ref_ok) begin
                    state_d = ST_COUNT;
                    cnt_d   = reload;
                end
            end
            default: begin
                // unused code: fall back to a stopped counter
                state_d = ST_IDLE;
                cnt_d   = CNT_RST;
            end
        endcase
    end

    // flag events and clears, laid out as status bits 15:14
    assign flag_set = {ref_bad, undf_ev};
    assign flag_clr = {2{wr_stat}} & WDATA_IN[REFE_POS:UNDF_POS];

    // sticky flags, one copy per bit; a new event wins over a clear
    // in the same cycle, so no event is lost to a late clear
    generate
        for (genvar gi = 0; gi < 2; gi++) begin : g_flag
            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    flag_q[gi] <= 1'b0;
                end else begin
                    flag_q[gi] <= flag_set[gi] | (flag_q[gi] & ~flag_clr[gi]);
                end
            end
        end
    endgenerate

    // named views of the two flags
    assign undf_q = flag_q[0];
    assign refe_q = flag_q[1];

    // control and mask writes; reserved control bits stay zero
    // only bits 15:14 of the mask exist, matching the two flags
    assign ctrl_d = wr_ctrl ? (WDATA_IN & CONTROL_WMASK) : ctrl_q;
    assign mask_d = wr_mask ? (WDATA_IN & 16'hc000) : mask_q;

    // status word: counter low, flags on top
    // reading clears nothing; the value is a live snapshot
    assign status = {refe_q, undf_q, cnt_q};

    // read mux; unmapped offsets read zero
    // reads have no side effects; flags clear only by writing ones
    assign rdata_d = sel_ctrl ? ctrl_q :
                     sel_stat ? status :
                     sel_mask ? mask_q : 16'h0000;

    // control register; a write lands at the strobe edge
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            ctrl_q <= CONTROL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // interrupt mask register
    // only the two flag bits exist, the rest read zero
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            mask_q <= MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // counter state; idle until the first refresh after reset
    // an illegal code cannot persist, the next state logic clears it
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // counter value
    // the full count shows while idle after reset
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // read data stand only in the cycle after the strobe
    // zero outside the slot keeps a shared read bus quiet
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            rdata_q <= 16'h0000;
        end else if (RD_IN) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    // underflow pulse registered for a clean output
    // one cycle late, but free of decode glitches
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            undf_ev_q <= 1'b0;
        end else begin
            undf_ev_q <= undf_ev;
        end
    end

    // outputs straight from flops, except the interrupt level
    assign RDATA_OUT     = rdata_q;
    assign UNDERFLOW_OUT = undf_ev_q;
    // level interrupt while any unmasked flag is set
    // the level falls as soon as software clears or masks the flag
    assign irq_flags     = flag_q & mask_q[REFE_POS:UNDF_POS];
    assign IRQ_OUT       = |irq_flags;
endmodule // iwd_watchdog

// ---- verification/iwd_watchdog_checker.sv ----
`timescale 1ns/100ps
module iwd_watchdog_checker
    import iwd_pkg::*;
(
    // clock and reset
    input wire logic              CLOCK_IN,
    input wire logic              RST_N_IN,
    // register port
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WDATA_IN,
    input wire logic              WR_IN,
    input wire logic              RD_IN,
    input wire logic [DATA_W-1:0] RDATA_OUT,
    // events
    input wire logic              UNDERFLOW_OUT,
    input wire logic              IRQ_OUT
);
    logic [15:0] ctrl_q; // control as software left it
    logic [15:0] mask_q; // mask as software left it
    logic        idle_q; // counter stopped
    logic [1:0]  wrh_q;  // recent refresh or mask writes
    logic [14:0] per;    // selected period
    // flag may land one edge late, so two cycles of history
    assign per = (ctrl_q[1:0] == 2'h0) ? PERIOD_0 : (ctrl_q[1:0] == 2'h1) ? PERIOD_1 :
                 (ctrl_q[1:0] == 2'h2) ? PERIOD_2 : PERIOD_3;
    // shadow of the writable state
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            ctrl_q <= CONTROL_RST;
            mask_q <= MASK_RST;
            idle_q <= 1'b1;
            wrh_q  <= 2'b00;
        end else begin
            if (WR_IN && ADDR_IN == OFS_CONTROL)
                ctrl_q <= WDATA_IN & CONTROL_WMASK;
            if (WR_IN && ADDR_IN == OFS_MASK)
                mask_q <= {WDATA_IN[15:14], 14'h0000};
            if (UNDERFLOW_OUT)
                idle_q <= 1'b1;
            else if (WR_IN && ADDR_IN == OFS_REFRESH)
                idle_q <= 1'b0;
            wrh_q <= {wrh_q[0], WR_IN && ADDR_IN[3]};
        end
    end
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);
    // refresh while stopped, then a status read
    sequence s_fresh;
        WR_IN && ADDR_IN == OFS_REFRESH && idle_q;
    endsequence
    sequence s_stat;
        RD_IN && ADDR_IN == OFS_STATUS;
    endsequence
    a_fresh_load: assert property (s_fresh ##[1:2] s_stat |=> RDATA_OUT[13:0] == per[13:0] - 14'h0001)
        else $error("reload value wrong");
    a_ctrl_back: assert property (RD_IN && ADDR_IN == OFS_CONTROL |=> RDATA_OUT == ctrl_q)
        else $error("control readback wrong");
    a_mask_back: assert property (RD_IN && ADDR_IN == OFS_MASK |=> RDATA_OUT == mask_q)
        else $error("mask readback wrong");
    a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
        else $error("read data outside slot");
    a_unmapped_zero: assert property (RD_IN && (ADDR_IN[1:0] != 2'b00 || ADDR_IN == OFS_REFRESH) |=> RDATA_OUT == 16'h0000)
        else $error("unmapped read not zero");
    a_under_pulse: assert property ($rose(UNDERFLOW_OUT) |=> !UNDERFLOW_OUT)
        else $error("underflow pulse too long");
    a_under_irq: assert property (UNDERFLOW_OUT && mask_q[14] |-> IRQ_OUT)
        else $error("underflow without interrupt");
    a_irq_masked: assert property (IRQ_OUT |-> mask_q[15:14] != 2'b00)
        else $error("interrupt while masked");
    a_irq_cause: assert property ($rose(IRQ_OUT) && wrh_q == 2'b00 |-> UNDERFLOW_OUT)
        else $error("interrupt without cause");
    a_clear_irq: assert property (WR_IN && ADDR_IN == OFS_STATUS && (WDATA_IN[15:14] | ~mask_q[15:14]) == 2'b11 |=> !IRQ_OUT)
        else $error("flag clear left interrupt");
endmodule // iwd_watchdog_checker
bind iwd_watchdog iwd_watchdog_checker u_chk (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .UNDERFLOW_OUT(UNDERFLOW_OUT), .IRQ_OUT(IRQ_OUT));

// ---- verification/independent_window_watchdog_regs_bench.sv ----
`timescale 1ns/100ps
module independent_window_watchdog_regs_bench;
    import iwd_pkg::*;
    logic        clk;     // system clock
    logic        rst_n;   // reset, active low
    logic [3:0]  addr;    // register address
    logic [15:0] wdata;   // write data
    logic        wr;      // write strobe
    logic        rd;      // read strobe
    logic [15:0] rdata;   // read data
    logic        src;     // watchdog source clock
    logic        under;   // underflow pulse
    logic        irq;     // interrupt level
    int          bad_count, comparisons, unds, m, i, seed;
    logic [15:0] e;       // expected status
    int          per [4] = '{1024, 4096, 8192, 16384};
    int          rat [6] = '{1, 16, 32, 64, 128, 256};
    logic [3:0]  cod [6] = '{CKS_DIV1, CKS_DIV16, CKS_DIV32, CKS_DIV64, CKS_DIV128, CKS_DIV256};
    int          tg [5] = '{1023, 512, 511, 256, 255};
    iwd_watchdog dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SRC_CLK_IN(src),
        .UNDERFLOW_OUT(under), .IRQ_OUT(irq));
    // free running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count underflow pulses
    always @(posedge clk) begin
        if (!rst_n)
            unds <= 0;
        else if (under === 1'b1)
            unds <= unds + 1;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    // rising edges of the source clock, 4 cycles per half
    task automatic edges(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge clk);
            src <= ~src;
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic rst_pulse();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic summarize();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial begin
        {rst_n, wr, rd, src, addr, wdata} = '0;
        seed = 32'hecba619b;
        rst_pulse();
        rd_reg(OFS_CONTROL, CONTROL_RST);
        rd_reg(OFS_STATUS, 16'h3fff);
        rd_reg(4'h2, 16'h0000);
        rd_reg(OFS_REFRESH, 16'h0000);
        // random field values, readback masked to writable bits
        for (i = 0; i < 6; i++) begin
            // random fields, divider kept to an allowed code
            e = (16'($random(seed)) & 16'hff0f) | (16'(cod[i]) << 4);
            wr_reg(OFS_CONTROL, e);
            rd_reg(OFS_CONTROL, e & CONTROL_WMASK);
            wr_reg(OFS_MASK, e);
            rd_reg(OFS_MASK, e & 16'hc000);
        end
        // reset per code so the prescaler phase starts clean
        for (i = 0; i < 6; i++) begin
            rst_pulse();
            wr_reg(OFS_CONTROL, 16'h3300 | (16'(cod[i]) << 4) | 16'(i % 4));
            wr_reg(OFS_REFRESH, 16'h0000);
            rd_reg(OFS_STATUS, 16'(per[i % 4] - 1));
            edges(2 * rat[i]);
            rd_reg(OFS_STATUS, 16'(per[i % 4] - 3));
        end
        // run to underflow; counter must stop at zero
        rst_pulse();
        wr_reg(OFS_MASK, 16'h4000);
        wr_reg(OFS_CONTROL, 16'h3300);
        wr_reg(OFS_REFRESH, 16'h0000);
        edges(1026);
        rd_reg(OFS_STATUS, 16'h4000);
        chk(16'(unds), 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(OFS_MASK, 16'h0000);
        @(negedge clk);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(OFS_MASK, 16'h4000);
        wr_reg(OFS_STATUS, 16'h4000);
        rd_reg(OFS_STATUS, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // window opens below 512 and closes below 256
        rst_pulse();
        wr_reg(OFS_MASK, 16'h8000);
        wr_reg(OFS_CONTROL, 16'h1200);
        wr_reg(OFS_REFRESH, 16'h0000);
        m = 1023;
        for (i = 0; i < 5; i++) begin
            edges(m - tg[i]);
            wr_reg(OFS_REFRESH, 16'h0000);
            // inside the window the count reloads, outside it stays and flags
            m = (tg[i] < 512 && tg[i] >= 256) ? 1023 : tg[i];
            e = (tg[i] < 512 && tg[i] >= 256) ? 16'(m) : 16'h8000 | 16'(m);
            rd_reg(OFS_STATUS, e);
            chk({15'h0000, irq}, {15'h0000, e[15]});
            wr_reg(OFS_STATUS, 16'h8000);
        end
        summarize();
    end
    // hang guard, about one and a half times the expected run
    initial begin
        #1000000;
        bad_count++;
        summarize();
    end
endmodule // independent_window_watchdog_regs_bench
